//--- mia_map.vh
// Purpose: Register offsets, field positions, reset values and timing counts for the
//          maskable interrupt acceptance block.
// Assumes: Byte-wide special-function register port from the CPU core.
// Notes:   Definitions only; included by bare name.
`ifndef MIA_MAP_VH
`define MIA_MAP_VH

// ****************************************************************
// Register offsets in the special-function area
// ****************************************************************
`define MIA_ADDR_W          8
`define MIA_OFS_ENA_HIGH    8'h2C
`define MIA_OFS_ENA_LOW     8'h3A
`define MIA_OFS_ENA_MID     8'h3B
`define MIA_OFS_REQ_HIGH    8'h2E
`define MIA_OFS_REQ_LOW     8'h3C
`define MIA_OFS_REQ_MID     8'h3D

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define MIA_MASTER_BIT      0
`define MIA_ATRAP_BIT       2
`define MIA_WDT_BIT         3
`define MIA_FIRST_MASKABLE  4
`define MIA_NUM_SRC         24
`define MIA_ENA_RESET       24'h000000
`define MIA_REQ_RESET       24'h000000
`define MIA_MASTER_RESET    1'b0

// ****************************************************************
// Acceptance sequence timing
// ****************************************************************
`define MIA_ACCEPT_MCYC     8
`define MIA_CLK_PER_MCYC    4
`define MIA_ACCEPT_CLKS     (`MIA_ACCEPT_MCYC * `MIA_CLK_PER_MCYC)
`define MIA_MAX_LATENCY     38
`define MIA_SP_DROP         16'h0003

// Sequence steps
`define MIA_STEP_IDLE       3'h0
`define MIA_STEP_STATUS     3'h1
`define MIA_STEP_PC_HI      3'h2
`define MIA_STEP_PC_LO      3'h3
`define MIA_STEP_VEC        3'h4
`define MIA_STEP_WAIT       3'h5

`endif

//--- mia_prio_pick.v
// Purpose: Fixed-priority pick of the lowest-numbered pending source.
// Assumes: Bit 0 is the highest priority.
// Notes:   Pure combinational.
`timescale 1ns/1ps

module mia_prio_pick #(
  parameter N = 24,
  parameter W = 5
) (
  input  wire [N-1:0] i_req,
  output reg          o_any,
  output reg  [W-1:0] o_idx
);

  integer k;

  // ****************************************************************
  // Scan from lowest priority upward so the highest wins
  // ****************************************************************
  always @* begin
    o_any = 1'b0;
    o_idx = {W{1'b0}};
    for (k = N-1; k >= 0; k = k - 1) begin
      if (i_req[k]) begin
        o_any = 1'b1;
        o_idx = k[W-1:0];
      end
    end
  end

endmodule

//--- mia_latch_bank.v
// Purpose: Request latches set by hardware events, cleared by writes or acceptance.
// Assumes: A set arriving in the clear cycle wins.
// Notes:   Software writes of 1 leave a latch alone.
`timescale 1ns/1ps

module mia_latch_bank #(
  parameter N = 24
) (
  input  wire         i_core_clk,
  input  wire         i_nrst,
  input  wire [N-1:0] i_set,
  input  wire [N-1:0] i_sw_clr,
  input  wire [N-1:0] i_ack_clr,
  output reg  [N-1:0] o_latch_r
);

  // ****************************************************************
  // Latch storage
  // ****************************************************************
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_latch_r <= {N{1'b0}};
    end else begin
      o_latch_r <= (o_latch_r & ~(i_sw_clr | i_ack_clr)) | i_set;
    end
  end

endmodule

//--- mia_accept.v
// Purpose: Interrupt enable flags, request latches and the acceptance sequence.
// Assumes: Core issues byte reads and writes to the special-function area; the core
//          raises i_instr_done in the final cycle of each instruction.
// Notes:   Sources 0,1 have no latch (software, undefined instruction); 2,3 non-maskable.
`timescale 1ns/1ps
`include "mia_map.vh"

module mia_accept #(
  parameter N           = `MIA_NUM_SRC,
  parameter IW          = 5,
  parameter ACCEPT_CLKS = `MIA_ACCEPT_CLKS
) (
  input  wire         i_core_clk,
  input  wire         i_nrst,
  input  wire [7:0]   i_sfr_addr,
  input  wire         i_sfr_wr,
  input  wire         i_sfr_rd,
  input  wire [7:0]   i_sfr_wdata,
  output reg  [7:0]   o_sfr_rdata,
  output wire         o_sfr_hit,
  input  wire [N-1:0] i_src_event,
  input  wire         i_swi,
  input  wire         i_undef,
  input  wire         i_enable_all_instr,
  input  wire         i_mask_all_instr,
  input  wire         i_return_instr,
  input  wire [7:0]   i_stacked_status,
  input  wire         i_instr_done,
  input  wire [15:0]  i_prog_counter,
  input  wire [7:0]   i_status_word,
  input  wire [15:0]  i_sp,
  output wire         o_int_pending,
  output reg          o_busy_r,
  output reg          o_push_r,
  output reg  [15:0]  o_push_addr_r,
  output reg  [7:0]   o_push_data_r,
  output reg          o_pc_load_r,
  output reg  [15:0]  o_vector_addr_r,
  output reg  [15:0]  o_sp_new_r,
  output reg          o_sp_load_r,
  output reg          o_done_r,
  output reg  [IW-1:0] o_src_idx_r,
  output wire         o_master_int_enable
);

  // ****************************************************************
  // Enable flags
  // ****************************************************************
  reg          master_int_enable_r;
  reg  [N-1:0] source_enable_flags_r;
  wire [N-1:0] request_latches;
  reg  [N-1:0] ack_clr_r;
  reg  [N-1:0] sw_clr;
  reg  [2:0]   step_r;
  reg  [5:0]   cnt_r;
  reg  [7:0]   saved_status_r;
  reg  [15:0]  saved_pc_r;
  wire         wr_ena_low;
  wire         wr_ena_mid;
  wire         wr_ena_high;
  wire         accept_start;

  assign wr_ena_low  = i_sfr_wr && (i_sfr_addr == `MIA_OFS_ENA_LOW);
  assign wr_ena_mid  = i_sfr_wr && (i_sfr_addr == `MIA_OFS_ENA_MID);
  assign wr_ena_high = i_sfr_wr && (i_sfr_addr == `MIA_OFS_ENA_HIGH);
  assign o_master_int_enable = master_int_enable_r;

  // Master flag: reset, instructions, register write, acceptance, return
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      master_int_enable_r <= `MIA_MASTER_RESET;
    end else if (accept_start) begin
      master_int_enable_r <= 1'b0;
    end else if (i_return_instr) begin
      master_int_enable_r <= i_stacked_status[`MIA_MASTER_BIT];
    end else if (i_enable_all_instr) begin
      master_int_enable_r <= 1'b1;
    end else if (i_mask_all_instr) begin
      master_int_enable_r <= 1'b0;
    end else if (wr_ena_low) begin
      master_int_enable_r <= i_sfr_wdata[`MIA_MASTER_BIT];
    end
  end

  // Individual flags; mid and high bytes written whole, low byte only bits 7:4
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      source_enable_flags_r <= `MIA_ENA_RESET;
    end else begin
      if (wr_ena_low) begin
        source_enable_flags_r[7:4] <= i_sfr_wdata[7:4];
      end
      if (wr_ena_mid) begin
        source_enable_flags_r[15:8] <= i_sfr_wdata;
      end
      if (wr_ena_high) begin
        source_enable_flags_r[N-1:16] <= i_sfr_wdata[N-17:0];
      end
    end
  end

  // ****************************************************************
  // Request latches
  // ****************************************************************
  // Software clear mask: a written 0 clears, only for latched sources
  always @* begin
    sw_clr = {N{1'b0}};
    if (i_sfr_wr && i_sfr_addr == `MIA_OFS_REQ_LOW) begin
      sw_clr[7:2] = ~i_sfr_wdata[7:2];
    end
    if (i_sfr_wr && i_sfr_addr == `MIA_OFS_REQ_MID) begin
      sw_clr[15:8] = ~i_sfr_wdata;
    end
    if (i_sfr_wr && i_sfr_addr == `MIA_OFS_REQ_HIGH) begin
      sw_clr[N-1:16] = ~i_sfr_wdata[N-17:0];
    end
  end

  mia_latch_bank #(
    .N (N)
  ) u_latch (
    .i_core_clk (i_core_clk),
    .i_nrst     (i_nrst),
    .i_set      ({i_src_event[N-1:2], 2'b00}),
    .i_sw_clr   (sw_clr),
    .i_ack_clr  (ack_clr_r),
    .o_latch_r  (request_latches)
  );

  // ****************************************************************
  // Register read-back
  // ****************************************************************
  assign o_sfr_hit = (i_sfr_addr == `MIA_OFS_ENA_LOW)  || (i_sfr_addr == `MIA_OFS_ENA_MID)  ||
                     (i_sfr_addr == `MIA_OFS_ENA_HIGH) || (i_sfr_addr == `MIA_OFS_REQ_LOW)  ||
                     (i_sfr_addr == `MIA_OFS_REQ_MID)  || (i_sfr_addr == `MIA_OFS_REQ_HIGH);

  // Read data registered; unmapped or idle reads give zero
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_sfr_rdata <= 8'h00;
    end else if (i_sfr_rd) begin
      case (i_sfr_addr)
        `MIA_OFS_ENA_LOW:  o_sfr_rdata <= {source_enable_flags_r[7:4], 3'b000,
                                           master_int_enable_r};
        `MIA_OFS_ENA_MID:  o_sfr_rdata <= source_enable_flags_r[15:8];
        `MIA_OFS_ENA_HIGH: o_sfr_rdata <= source_enable_flags_r[N-1:16];
        `MIA_OFS_REQ_LOW:  o_sfr_rdata <= {request_latches[7:2], 2'b00};
        `MIA_OFS_REQ_MID:  o_sfr_rdata <= request_latches[15:8];
        `MIA_OFS_REQ_HIGH: o_sfr_rdata <= request_latches[N-1:16];
        default:           o_sfr_rdata <= 8'h00;
      endcase
    end else begin
      o_sfr_rdata <= 8'h00;
    end
  end

  // ****************************************************************
  // Qualification and priority
  // ****************************************************************
  wire [N-1:0] nmi_req;
  wire [N-1:0] mask_req;
  wire [N-1:0] cand;
  wire         cand_any;
  wire [IW-1:0] cand_idx;

  // Non-maskable sources skip every enable flag
  assign nmi_req  = {{(N-4){1'b0}}, request_latches[3:2], i_undef, i_swi};
  // Maskable needs latch, own flag and master flag together
  assign mask_req = {request_latches[N-1:4] & source_enable_flags_r[N-1:4]
                     & {(N-4){master_int_enable_r}}, 4'h0};
  assign cand = nmi_req | mask_req;
  assign o_int_pending = cand_any;

  mia_prio_pick #(
    .N (N),
    .W (IW)
  ) u_pick (
    .i_req (cand),
    .o_any (cand_any),
    .o_idx (cand_idx)
  );

  // Sampled at the final cycle of the instruction in progress
  assign accept_start = (step_r == `MIA_STEP_IDLE) && i_instr_done && cand_any;

  // Vector for a source: FFFE minus two per rank, sources 0 and 1 both FFFC, second table below FFC0
  function [15:0] vec_of;
    input [IW-1:0] idx;
    reg   [15:0]   rank;
    begin
      rank = {{(16-IW){1'b0}}, idx};
      if (idx <= 5'd1) begin
        vec_of = 16'hFFFC;
      end else if (idx <= 5'd15) begin
        vec_of = 16'hFFFC - ((rank - 16'h0001) << 1);
      end else begin
        vec_of = 16'hFFBE - ((rank - 16'h0010) << 1);
      end
    end
  endfunction

  // ****************************************************************
  // Acceptance sequence
  // ****************************************************************
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      step_r          <= `MIA_STEP_IDLE;
      cnt_r           <= 6'h00;
      saved_status_r  <= 8'h00;
      saved_pc_r      <= 16'h0000;
      ack_clr_r       <= {N{1'b0}};
      o_busy_r        <= 1'b0;
      o_push_r        <= 1'b0;
      o_push_addr_r   <= 16'h0000;
      o_push_data_r   <= 8'h00;
      o_pc_load_r     <= 1'b0;
      o_vector_addr_r <= 16'h0000;
      o_sp_new_r      <= 16'h0000;
      o_sp_load_r     <= 1'b0;
      o_done_r        <= 1'b0;
      o_src_idx_r     <= {IW{1'b0}};
    end else begin
      ack_clr_r   <= {N{1'b0}};
      o_push_r    <= 1'b0;
      o_pc_load_r <= 1'b0;
      o_sp_load_r <= 1'b0;
      o_done_r    <= 1'b0;
      if (step_r != `MIA_STEP_IDLE) begin
        cnt_r <= cnt_r + 6'h01;
      end
      case (step_r)
        `MIA_STEP_IDLE: begin
          if (accept_start) begin
            // Only status and PC are captured; general registers are software's job
            saved_status_r <= {i_status_word[7:1], master_int_enable_r};
            saved_pc_r     <= i_prog_counter;
            ack_clr_r      <= {{(N-1){1'b0}}, 1'b1} << cand_idx;
            o_src_idx_r    <= cand_idx;
            o_busy_r       <= 1'b1;
            cnt_r          <= 6'h01;
            step_r         <= `MIA_STEP_STATUS;
          end
        end
        `MIA_STEP_STATUS: begin
          o_push_r      <= 1'b1;
          o_push_addr_r <= i_sp;
          o_push_data_r <= saved_status_r;
          step_r        <= `MIA_STEP_PC_HI;
        end
        `MIA_STEP_PC_HI: begin
          o_push_r      <= 1'b1;
          o_push_addr_r <= i_sp - 16'h0001;
          o_push_data_r <= saved_pc_r[15:8];
          step_r        <= `MIA_STEP_PC_LO;
        end
        `MIA_STEP_PC_LO: begin
          o_push_r      <= 1'b1;
          o_push_addr_r <= i_sp - 16'h0002;
          o_push_data_r <= saved_pc_r[7:0];
          o_sp_new_r    <= i_sp - `MIA_SP_DROP;
          o_sp_load_r   <= 1'b1;
          step_r        <= `MIA_STEP_VEC;
        end
        `MIA_STEP_VEC: begin
          o_vector_addr_r <= vec_of(o_src_idx_r);
          o_pc_load_r     <= 1'b1;
          step_r          <= `MIA_STEP_WAIT;
        end
        `MIA_STEP_WAIT: begin
          // Pad out to the full eight machine cycles
          if (cnt_r == ACCEPT_CLKS[5:0]) begin
            o_busy_r <= 1'b0;
            o_done_r <= 1'b1;
            step_r   <= `MIA_STEP_IDLE;
          end
        end
        default: begin
          step_r   <= `MIA_STEP_IDLE;
          o_busy_r <= 1'b0;
        end
      endcase
    end
  end

endmodule

//--- mia_accept_properties.sv
// Purpose: Port-level timing checks on the acceptance block.
// Assumes: One clock domain; async active-low reset.
// Notes:   Bound to the design from the bench top file.
`timescale 1ns/1ps
module mia_accept_properties #(
  parameter int ACCEPT_CLKS = 32
) (
  input logic        i_core_clk,
  input logic        i_nrst,
  input logic [7:0]  i_sfr_addr,
  input logic        i_sfr_rd,
  input logic [7:0]  o_sfr_rdata,
  input logic        o_sfr_hit,
  input logic        i_enable_all_instr,
  input logic        i_mask_all_instr,
  input logic        i_return_instr,
  input logic [7:0]  i_stacked_status,
  input logic        i_instr_done,
  input logic [15:0] i_sp,
  input logic        o_int_pending,
  input logic        o_busy_r,
  input logic        o_push_r,
  input logic [15:0] o_push_addr_r,
  input logic [15:0] o_sp_new_r,
  input logic        o_sp_load_r,
  input logic        o_pc_load_r,
  input logic        o_done_r,
  input logic        o_master_int_enable
);
  // ****
  // Helpers and sequences
  // ****
  // Acceptance is taken at an instruction end while idle
  wire acc  = i_instr_done && !o_busy_r && o_int_pending;
  wire stk0 = i_stacked_status[0];
  // Done is launched on the last counted edge, so it is sampled one edge later
  localparam int DONE_AT = ACCEPT_CLKS + 1;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  // Three pushes, the last with the stack pointer load
  sequence s_push;
    ##2 o_push_r ##1 o_push_r ##1 (o_push_r && o_sp_load_r);
  endsequence
  sequence s_vec;
    ##1 o_pc_load_r;
  endsequence
  // ****
  // Assertions
  // ****
  accept_start_a: assert property (acc |=> o_busy_r && !o_master_int_enable)
    else $error("acceptance did not start");
  push_order_a: assert property (acc |-> s_push ##0 s_vec)
    else $error("push sequence wrong");
  push_addr_a: assert property (acc |-> ##2 o_push_addr_r == $past(i_sp, 2))
    else $error("first push address wrong");
  sp_drop_a: assert property (o_sp_load_r |-> o_sp_new_r == o_push_addr_r - 16'h0001)
    else $error("stack pointer drop wrong");
  accept_len_a: assert property (acc |-> ##DONE_AT o_done_r)
    else $error("acceptance length wrong");
  enable_all_a: assert property (i_enable_all_instr && !acc && !i_return_instr
    |=> o_master_int_enable)
    else $error("enable-all missed");
  mask_all_a: assert property (i_mask_all_instr && !i_enable_all_instr && !i_return_instr
    |=> !o_master_int_enable)
    else $error("mask-all missed");
  return_load_a: assert property (i_return_instr && !acc
    |=> o_master_int_enable == $past(stk0))
    else $error("return did not restore master");
  unmapped_rd_a: assert property (i_sfr_rd && !o_sfr_hit |=> o_sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  hit_map_a: assert property (o_sfr_hit == (i_sfr_addr inside
    {8'h2C, 8'h3A, 8'h3B, 8'h2E, 8'h3C, 8'h3D}))
    else $error("address decode wrong");
endmodule

//--- mia_core_model.sv
// Purpose: Core sequencer model facing the acceptance block.
// Assumes: Instruction length in clocks set by the bench.
// Notes:   Keeps a byte image of the stack for the bench.
`timescale 1ns/1ps
module mia_core_model (
  input  logic        i_core_clk,
  input  logic        i_nrst,
  input  logic [3:0]  i_len,
  input  logic        i_busy,
  input  logic        i_push,
  input  logic [15:0] i_push_addr,
  input  logic [7:0]  i_push_data,
  input  logic        i_sp_load,
  input  logic [15:0] i_sp_new,
  input  logic        i_pc_load,
  input  logic [15:0] i_vec,
  output logic        o_done,
  output logic [15:0] o_pc,
  output logic [15:0] o_sp,
  output logic [7:0]  o_status
);
  logic [7:0] mem [0:511];
  logic [3:0] cnt;
  // Instruction end pulses; withheld while acceptance runs, the length counter keeps running
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt    <= 4'h0;
      o_done <= 1'b0;
      o_pc   <= 16'h1234;
      o_sp   <= 16'h01F0;
      o_status <= 8'hA6;
    end else begin
      o_done <= !i_busy && cnt == 4'h1;
      cnt    <= (cnt <= 4'h1) ? i_len : cnt - 4'h1;
      if (i_push) mem[i_push_addr[8:0]] <= i_push_data;
      if (i_sp_load) o_sp <= i_sp_new;
      if (i_pc_load) o_pc <= i_vec;
    end
  end
endmodule

//--- maskable_interrupt_acceptance_tb.sv
// Purpose: Self-checking bench; the bench plays software and sources.
// Assumes: Core model drives instruction ends and core state.
// Notes:   Bench keeps its own image of flags and latches.
`timescale 1ns/1ps
module maskable_interrupt_acceptance_tb;
  logic clk = 0, nrst = 0, wr = 0, rd = 0, swi = 0, und = 0, ena = 0, msk = 0, ret = 0;
  logic [7:0] addr = 0, wdat = 0, stk = 0, rdat, pdat, stw;
  logic [23:0] ev = 0, m_ena = 0, m_lat = 0;
  logic [3:0] len = 4'h2;
  logic hit, pend, busy, push, pcld, spl, done, mst, idn, m_mst = 0;
  logic [15:0] paddr, vec, spn, pc, sp;
  logic [4:0] sidx;
  logic [7:0] regs [7] = '{8'h3A, 8'h3B, 8'h2C, 8'h3C, 8'h3D, 8'h2E, 8'h50};
  int miscompares = 0, n_tests = 0, cyc = 0, k, s;
  always #12.5 clk = ~clk;
  mia_accept i_dut (.i_core_clk(clk), .i_nrst(nrst), .i_sfr_addr(addr), .i_sfr_wr(wr),
    .i_sfr_rd(rd), .i_sfr_wdata(wdat), .o_sfr_rdata(rdat), .o_sfr_hit(hit),
    .i_src_event(ev), .i_swi(swi), .i_undef(und), .i_enable_all_instr(ena),
    .i_mask_all_instr(msk), .i_return_instr(ret), .i_stacked_status(stk),
    .i_instr_done(idn), .i_prog_counter(pc), .i_status_word(stw), .i_sp(sp),
    .o_int_pending(pend), .o_busy_r(busy), .o_push_r(push), .o_push_addr_r(paddr),
    .o_push_data_r(pdat), .o_pc_load_r(pcld), .o_vector_addr_r(vec), .o_sp_new_r(spn),
    .o_sp_load_r(spl), .o_done_r(done), .o_src_idx_r(sidx), .o_master_int_enable(mst));
  mia_core_model i_core (.i_core_clk(clk), .i_nrst(nrst), .i_len(len), .i_busy(busy),
    .i_push(push), .i_push_addr(paddr), .i_push_data(pdat), .i_sp_load(spl),
    .i_sp_new(spn), .i_pc_load(pcld), .i_vec(vec), .o_done(idn), .o_pc(pc), .o_sp(sp),
    .o_status(stw));
  // ****
  // Tasks
  // ****
  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick();
    @(posedge clk);
    #2;
  endtask
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Expected read value from the bench image
  function automatic logic [7:0] erd(input logic [7:0] a);
    case (a)
      8'h3A: erd = {m_ena[7:4], 3'b000, m_mst};
      8'h3B: erd = m_ena[15:8];
      8'h2C: erd = m_ena[23:16];
      8'h3C: erd = {m_lat[7:2], 2'b00};
      8'h3D: erd = m_lat[15:8];
      8'h2E: erd = m_lat[23:16];
      default: erd = 8'h00;
    endcase
  endfunction
  // Register write; latch bytes only clear on zeros
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdat = d;
    wr = 1;
    tick();
    wr = 0;
    case (a)
      8'h3A: m_ena[7:4] = d[7:4];
      8'h3B: m_ena[15:8] = d;
      8'h2C: m_ena[23:16] = d;
      8'h3C: m_lat[7:0] &= {d[7:2], 2'b11};
      8'h3D: m_lat[15:8] &= d;
      8'h2E: m_lat[23:16] &= d;
      default: ;
    endcase
    if (a == 8'h3A) m_mst = d[0];
    // Let an edge pass so a following strobe is not re-driven in the same step
    tick();
  endtask
  task automatic rreg(input logic [7:0] a);
    addr = a;
    rd = 1;
    tick();
    rd = 0;
    chk(rdat, erd(a));
    tick();
  endtask
  task automatic pulse(input logic [23:0] m);
    ev = m;
    tick();
    ev = 0;
    m_lat |= m;
  endtask
  // Instruction: 0 enable-all, 1 mask-all, 2 return
  task automatic op(input int w, input logic [7:0] d);
    ena = (w == 0);
    msk = (w == 1);
    ret = (w == 2);
    stk = d;
    tick();
    {ena, msk, ret} = 3'b000;
    m_mst = (w == 0) ? 1'b1 : (w == 1) ? 1'b0 : d[0];
    chk(mst, m_mst);
    tick();
  endtask
  // Follow one acceptance and check the stack and vector
  task automatic accept(input int idx);
    int n;
    logic [15:0] s0, p0;
    logic b0;
    s0 = sp;
    p0 = pc;
    b0 = m_mst;
    n = 0;
    while (busy !== 1'b1 && n < 38) begin
      tick();
      n++;
    end
    chk(busy, 1);
    {swi, und} = 2'b00;
    while (done !== 1'b1 && n < 80) begin
      tick();
      n++;
    end
    tick();
    chk(sidx, idx);
    chk(mst, 0);
    chk(i_core.mem[s0[8:0]], {stw[7:1], b0});
    chk(i_core.mem[s0[8:0] - 9'h1], p0[15:8]);
    chk(i_core.mem[s0[8:0] - 9'h2], p0[7:0]);
    chk(sp, s0 - 16'h3);
    chk(pc, idx < 2 ? 16'hFFFC : idx < 16 ? 16'hFFFE - 2 * idx : 16'hFFDE - 2 * idx);
    m_mst = 0;
    if (idx > 1) m_lat[idx] = 0;
    rreg(idx < 8 ? 8'h3C : idx < 16 ? 8'h3D : 8'h2E);
    $display("Test done: source %0d accepted", idx);
  endtask
  // ****
  // Main sequence
  // ****
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      miscompares++;
      final_report();
    end
  end
  initial begin
    k = $urandom(32'hc123c0e1);
    repeat (5) @(posedge clk);
    #2 nrst = 1;
    foreach (regs[i]) rreg(regs[i]);
    op(1, 8'h00);
    for (k = 0; k < 3; k++) begin
      wreg(regs[k], 8'($urandom) & 8'hFE);
      rreg(regs[k]);
      wreg(regs[k], 8'h00);
    end
    $display("Test done: registers");
    pulse(24'h000020);
    wreg(8'h3C, 8'hFF);
    rreg(8'h3C);
    wreg(8'h3C, 8'hDF);
    rreg(8'h3C);
    wreg(8'h3C, 8'hFF);
    rreg(8'h3C);
    $display("Test done: latches");
    wreg(8'h3B, 8'h02);
    pulse(24'h000200);
    chk(pend, 0);
    op(0, 8'h00);
    accept(9);
    wreg(8'h3B, 8'h00);
    op(2, 8'h01);
    op(1, 8'h00);
    len = 4'hA;
    pulse(24'h000008);
    accept(3);
    op(2, 8'h00);
    wreg(8'h3A, 8'h20);
    op(0, 8'h00);
    pulse(24'h000028);
    accept(3);
    op(2, 8'($urandom) | 8'h01);
    accept(5);
    op(2, 8'h00);
    for (k = 0; k < 2; k++) begin
      swi = (k == 0);
      und = (k == 1);
      accept(k);
      op(2, 8'h00);
    end
    len = 4'h2;
    for (k = 0; k < 4; k++) begin
      s = 4 + $urandom % 20;
      op(1, 8'h00);
      wreg(s < 8 ? 8'h3A : s < 16 ? 8'h3B : 8'h2C, 8'(1 << (s % 8)));
      pulse(24'h1 << s);
      op(0, 8'h00);
      accept(s);
      op(2, 8'h00);
    end
    final_report();
  end
endmodule
bind mia_accept mia_accept_properties #(.ACCEPT_CLKS(ACCEPT_CLKS)) u_props (.i_core_clk,
  .i_nrst, .i_sfr_addr, .i_sfr_rd, .o_sfr_rdata, .o_sfr_hit, .i_enable_all_instr,
  .i_mask_all_instr, .i_return_instr, .i_stacked_status, .i_instr_done, .i_sp,
  .o_int_pending, .o_busy_r, .o_push_r, .o_push_addr_r, .o_sp_new_r, .o_sp_load_r,
  .o_pc_load_r, .o_done_r, .o_master_int_enable);
